/* design/flash_ctrl_defines.svh */
// Constants for the LED flash control register bank
// How it works
// - Update is start, address, select, data
// - Device acks every received byte low
// - Write applies at data-byte ack clock rise
// - First byte is address; respond on match
// - Select byte: upper six zero, low two index
// - Four 8-bit registers, read/write except reg1 bit 0 and reg2 bits 7:3
// - Mode bits written in reg1 mirror reg0
// - 400/500 mA needs unlock 0, mask, gpio
// - Mode 01 torch, 10 flash, 11 voltage
// - Thermal bit 0 normal, 1 tripped
// - Bits 3-5 set in torch/flash start measure
// - Reg2 bits 6:5 write limit, read fault/adc
// - Timer register resets to D1
// - Safety timer written once before flash
// - Safety timeout is field times 32.8 ms
// - Dimming code sets torch PWM duty
// - Voltage mode: expired flag after code*1.02 s
// - Switch limit selects 1000/1500/2000 mA
// - Fixed address 011 0011 only
// - No 10-bit or general call response
// - Unmapped register reads return 00h
// - Dimming PWM runs at 122 Hz
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

// ------------------------------------------------------------
// Addresses and reset values
// ------------------------------------------------------------
`define SLAVE_ADDR      7'h33
`define REG_LED         8'h00
`define REG_MODE        8'h01
`define REG_MEAS        8'h02
`define REG_TIMER       8'h03
`define TIMER_RST       8'hD1
`define BYTE_ZERO       8'h00
`define BIT_ACK         4'h8
`define MODE_OFF        2'h0
`define MODE_TORCH      2'h1
`define MODE_FLASH      2'h2
`define MODE_VOLT       2'h3
`define MEAS_TRIG       3'h7
`define TORCH_HI_MIN    3'h6
`define TORCH_CLAMP     3'h5
`define SWITCH_CURRENT_LIMIT_SELECT_MAX        2'h2
`define START_HOLD      5'h10

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UNLOCK_BIT      5
`define DIM_BIT         4
`define SWITCH_CURRENT_LIMIT_SELECT_HI         6
`define SWITCH_CURRENT_LIMIT_SELECT_LO         5
`define TRIG_HI         5
`define TRIG_LO         3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ         100
`define HZ_PER_MHZ      1000000
`define US_PER_MS       1000
`define SAFETY_STEP_US  32800
`define GP_STEP_MS      1020
`define DIM_PWM_HZ      122
`define PER_MILLE       1000
`define DUTY_PM         {10'h056, 10'h03F, 10'h02F, 10'h027, 10'h01F, 10'h017, 10'h010, 10'h008}

`endif

/* design/flash_ctrl_pkg.sv */
// Types shared by the LED flash control register bank
package flash_ctrl_pkg;

	// Transfer phase of the serial slave, Gray along the usual path
	typedef enum logic [2:0]
	{
		PH_ADDR  = 3'h0,
		PH_REG   = 3'h1,
		PH_WDATA = 3'h3,
		PH_RDATA = 3'h2,
		PH_SKIP  = 3'h6
	} phase_e;

	// Analog status inputs
	typedef struct packed
	{
		logic       thermal;
		logic       fault;
		logic [2:0] adc;
	} sense_s;

	// Controls to the power stage
	typedef struct packed
	{
		logic [1:0] mode;
		logic [2:0] torch;
		logic [2:0] flash;
		logic [1:0] switch_current_limit_select;
		logic       meas_start;
		logic       flash_en;
		logic       flash_timeout;
		logic       torch_pwm;
		logic       timer_expired;
	} ctrl_out_s;

	// Serial link state, rising edge of the serial clock
	typedef struct packed
	{
		phase_e     phase;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic [7:0] rd_sr;
		logic [7:0] sel;
		logic [7:0] wdat;
		logic       sel_tgl;
		logic       wr_tgl;
	} link_s;

	// Serial data drive, falling edge of the serial clock
	typedef struct packed
	{
		logic oe;
		logic out;
	} drive_s;

	// Core state on the system clock
	typedef struct packed
	{
		logic [1:0] scl_m;
		logic [1:0] sda_m;
		logic       sda_p;
		logic [1:0] txm_m;
		logic [1:0] gpio_m;
		sense_s     sense_m;
		sense_s     sense;
		logic [1:0] wr_m;
		logic       wr_seen;
		logic [1:0] sel_m;
		logic       sel_seen;
		logic       link_reset;
		logic [4:0] hold;
		logic [7:0] reg_sel;
		logic [1:0] mode;
		logic [5:0] r0_low;
		logic [5:0] r1_low;
		logic [2:0] r2_low;
		logic [1:0] switch_current_limit_select;
		logic [2:0] dct;
		logic [4:0] flash_safety_limit;
		logic       flash_safety_limit_locked;
		logic [31:0] fl_pre;
		logic [4:0] fl_steps;
		logic       fl_expired;
		logic [31:0] gp_pre;
		logic [2:0] gp_steps;
		logic       to_flag;
		logic [31:0] pwm_cnt;
		logic [7:0] rd_byte;
		ctrl_out_s  out;
	} core_s;

endpackage

/* design/led_flash_ctrl_regs.sv */
// Serial register bank and timers of the LED flash and torch driver
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"

module led_flash_ctrl_regs
#(
	parameter int unsigned SAFETY_STEP_CYC = `SAFETY_STEP_US * `CLK_MHZ,
	parameter int unsigned GP_STEP_CYC     = `GP_STEP_MS * `US_PER_MS * `CLK_MHZ,
	parameter int unsigned PWM_PERIOD_CYC  = `CLK_MHZ * `HZ_PER_MHZ / `DIM_PWM_HZ
)
(
	// System clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RST,
	// Serial port, clock from the master
	input  wire logic                     LINK_SCL,
	input  wire logic                     SDA_IN,
	output logic                          SDA_OUT,
	output logic                          SDA_OE,
	// Pin strobes and analog status
	input  wire logic                     TX_MASK_EN,
	input  wire logic                     GPIO_IN,
	input  wire flash_ctrl_pkg::sense_s   SENSE,
	// Power stage controls
	output flash_ctrl_pkg::ctrl_out_s     CTRL
);
	import flash_ctrl_pkg::*;

	link_s  link;
	link_s  next_link;
	drive_s drv;
	drive_s next_drv;
	core_s  core;
	core_s  next_core;
	logic   ack_now;
	logic   wr_evt;
	logic   sel_evt;
	logic [63:0] thresh;

	// ------------------------------------------------------------
	// Link domain: bit shifting and byte decisions
	// ------------------------------------------------------------

	// Ack after the address byte only on an exact match
	assign ack_now = (link.cnt == `BIT_ACK) &&
		(((link.phase == PH_ADDR) && (link.sr[7:1] == `SLAVE_ADDR)) ||
		(link.phase == PH_REG) || (link.phase == PH_WDATA));

	// Rising edge: sample the data line, act in the ack slot
	always_comb
	begin
		next_link = link;
		if (link.cnt != `BIT_ACK)
		begin
			next_link.sr    = {link.sr[6:0], SDA_IN};
			next_link.rd_sr = {link.rd_sr[6:0], 1'b1};
			next_link.cnt   = link.cnt + 4'h1;
		end
		else
		begin
			next_link.cnt = 4'h0;
			case (link.phase)
				PH_ADDR:
					if (link.sr[7:1] != `SLAVE_ADDR)
						next_link.phase = PH_SKIP;
					else if (link.sr[0])
					begin
						next_link.phase = PH_RDATA;
						next_link.rd_sr = core.rd_byte;
					end
					else
						next_link.phase = PH_REG;
				PH_REG:
				begin
					next_link.sel     = link.sr;
					next_link.sel_tgl = ~link.sel_tgl;
					next_link.phase   = PH_WDATA;
				end
				PH_WDATA:
				begin
					next_link.wdat   = link.sr;
					next_link.wr_tgl = ~link.wr_tgl;
				end
				PH_RDATA:
					if (SDA_IN)
						next_link.phase = PH_SKIP;
					else
						next_link.rd_sr = core.rd_byte;
				default:
					next_link.phase = link.phase;
			endcase
		end
	end

	// Link state, cleared between frames by the core
	always_ff @(posedge LINK_SCL or posedge core.link_reset)
	begin
		if (core.link_reset)
			link <= '{phase: PH_ADDR, default: '0};
		else
			link <= next_link;
	end

	// Falling edge: ack or read data, open drain low only
	always_comb
	begin
		next_drv     = '0;
		next_drv.oe  = ack_now ||
			((link.phase == PH_RDATA) && (link.cnt != `BIT_ACK) && !link.rd_sr[7]);
	end

	always_ff @(negedge LINK_SCL or posedge core.link_reset)
	begin
		if (core.link_reset)
			drv <= '0;
		else
			drv <= next_drv;
	end

	assign SDA_OE  = drv.oe;
	assign SDA_OUT = drv.out;

	// ------------------------------------------------------------
	// Core domain: framing, register file and timers
	// ------------------------------------------------------------

	// Toggles from the link; ignored while the link is held in reset
	assign wr_evt  = (core.wr_m[1] != core.wr_seen) && !core.link_reset;
	assign sel_evt = (core.sel_m[1] != core.sel_seen) && !core.link_reset;
	assign thresh  = 64'(PWM_PERIOD_CYC) * 64'(`DUTY_PM >> (10 * core.dct) & 80'h3FF)
		/ 64'(`PER_MILLE);

	always_comb
	begin
		next_core = core;
		// Two-flop synchronisers, the second stage is read; data adds a third stage, sda_p, for edges
		next_core.scl_m   = {core.scl_m[0], LINK_SCL};
		next_core.sda_m   = {core.sda_m[0], SDA_IN};
		next_core.sda_p   = core.sda_m[1];
		next_core.txm_m   = {core.txm_m[0], TX_MASK_EN};
		next_core.gpio_m  = {core.gpio_m[0], GPIO_IN};
		next_core.sense_m = SENSE;
		next_core.sense   = core.sense_m;
		next_core.wr_m    = {core.wr_m[0], link.wr_tgl};
		next_core.sel_m   = {core.sel_m[0], link.sel_tgl};
		next_core.out.meas_start = 1'b0;

		// Start releases the link after a short hold; stop holds it
		if (core.scl_m[1] && core.sda_p && !core.sda_m[1])
		begin
			next_core.link_reset = 1'b1;
			next_core.hold       = `START_HOLD;
		end
		else if (core.scl_m[1] && !core.sda_p && core.sda_m[1])
		begin
			next_core.link_reset = 1'b1;
			next_core.hold       = '0;
		end
		else if (core.hold != '0)
		begin
			next_core.hold = core.hold - 5'h1;
			next_core.link_reset = (core.hold != 5'h1);
		end

		// Toggles clearing back to zero under link reset are absorbed
		if (core.link_reset || sel_evt)
			next_core.sel_seen = core.sel_m[1];
		if (core.link_reset || wr_evt)
			next_core.wr_seen = core.wr_m[1];
		if (sel_evt)
			next_core.reg_sel = link.sel;

		// Register writes
		if (wr_evt)
		begin
			if (core.reg_sel == `REG_LED)
			begin
				next_core.mode   = link.wdat[7:6];
				next_core.r0_low = link.wdat[5:0];
			end
			else if (core.reg_sel == `REG_MODE)
			begin
				next_core.mode   = link.wdat[7:6];
				next_core.r1_low = link.wdat[5:0];
			end
			else if (core.reg_sel == `REG_MEAS)
			begin
				next_core.switch_current_limit_select   = link.wdat[`SWITCH_CURRENT_LIMIT_SELECT_HI:`SWITCH_CURRENT_LIMIT_SELECT_LO];
				next_core.r2_low = link.wdat[2:0];
				next_core.out.meas_start = (link.wdat[`TRIG_HI:`TRIG_LO] == `MEAS_TRIG) &&
					((core.mode == `MODE_TORCH) || (core.mode == `MODE_FLASH));
			end
			else if (core.reg_sel == `REG_TIMER)
			begin
				next_core.dct = link.wdat[7:5];
				if (!core.flash_safety_limit_locked)
				begin
					next_core.flash_safety_limit        = link.wdat[4:0];
					next_core.flash_safety_limit_locked = 1'b1;
				end
			end
		end
		if (next_core.mode == `MODE_FLASH)
			next_core.flash_safety_limit_locked = 1'b1;

		// Flash safety timer, restarted on each entry to flash mode
		if (core.mode != `MODE_FLASH)
		begin
			next_core.fl_pre     = '0;
			next_core.fl_steps   = '0;
			next_core.fl_expired = 1'b0;
		end
		else if (!core.fl_expired)
		begin
			if (core.fl_steps == core.flash_safety_limit)
				next_core.fl_expired = 1'b1;
			else if (core.fl_pre == SAFETY_STEP_CYC - 1)
			begin
				next_core.fl_pre   = '0;
				next_core.fl_steps = core.fl_steps + 5'h1;
			end
			else
				next_core.fl_pre = core.fl_pre + 32'h1;
		end

		// General purpose timer in voltage mode
		if (core.mode != `MODE_VOLT)
		begin
			next_core.gp_pre   = '0;
			next_core.gp_steps = '0;
			next_core.to_flag  = 1'b0;
		end
		else if (!core.to_flag)
		begin
			if (core.gp_steps == core.dct)
				next_core.to_flag = 1'b1;
			else if (core.gp_pre == GP_STEP_CYC - 1)
			begin
				next_core.gp_pre   = '0;
				next_core.gp_steps = core.gp_steps + 3'h1;
			end
			else
				next_core.gp_pre = core.gp_pre + 32'h1;
		end

		// Dimming PWM, fixed period
		if (core.pwm_cnt >= PWM_PERIOD_CYC - 1)
			next_core.pwm_cnt = '0;
		else
			next_core.pwm_cnt = core.pwm_cnt + 32'h1;

		// Read data for the link, sampled by it in the ack slot
		if (core.reg_sel == `REG_LED)
			next_core.rd_byte = {core.mode, core.r0_low};
		else if (core.reg_sel == `REG_MODE)
			next_core.rd_byte = {core.mode, core.r1_low[5:1], core.to_flag};
		else if (core.reg_sel == `REG_MEAS)
			next_core.rd_byte = {core.sense.thermal, core.sense.fault, core.sense.adc,
				core.r2_low};
		else if (core.reg_sel == `REG_TIMER)
			next_core.rd_byte = {core.dct, core.flash_safety_limit};
		else
			next_core.rd_byte = `BYTE_ZERO;

		// Outputs to the power stage
		next_core.out.mode  = core.mode;
		next_core.out.flash = core.r0_low[2:0];
		next_core.out.torch = core.r0_low[5:3];
		if ((core.r0_low[5:3] >= `TORCH_HI_MIN) && (core.r1_low[`UNLOCK_BIT] ||
			!core.txm_m[1] || !core.gpio_m[1]))
			next_core.out.torch = `TORCH_CLAMP;
		next_core.out.switch_current_limit_select = (core.switch_current_limit_select > `SWITCH_CURRENT_LIMIT_SELECT_MAX) ? `SWITCH_CURRENT_LIMIT_SELECT_MAX : core.switch_current_limit_select;
		next_core.out.flash_en      = (core.mode == `MODE_FLASH) && !core.fl_expired;
		next_core.out.flash_timeout = core.fl_expired;
		next_core.out.timer_expired = core.to_flag;
		next_core.out.torch_pwm     = (core.mode == `MODE_TORCH) &&
			(!core.r1_low[`DIM_BIT] || (64'(core.pwm_cnt) < thresh));
	end

	// Core register, synchronous reset
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			core            <= '0;
			core.link_reset <= 1'b1;
			{core.dct, core.flash_safety_limit} <= `TIMER_RST;
		end
		else
			core <= next_core;
	end

	assign CTRL = core.out;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	property p_ack_match;
		@(posedge LINK_SCL) disable iff (core.link_reset)
		(link.cnt == `BIT_ACK) && (link.phase == PH_ADDR) && (link.sr[7:1] == `SLAVE_ADDR)
		|-> drv.oe;
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("no ack on own address");

	property p_nack_other;
		@(posedge LINK_SCL) disable iff (core.link_reset)
		(link.phase == PH_ADDR) && (link.cnt == `BIT_ACK) && (link.sr[7:1] != `SLAVE_ADDR)
		|-> !drv.oe ##1 (link.phase == PH_SKIP);
	endproperty
	a_nack_other: assert property (p_nack_other) else $error("answered other address");

	property p_mode_mirror;
		@(posedge CLK) disable iff (RST)
		wr_evt && (core.reg_sel == `REG_MODE)
		|-> ##2 (core.rd_byte[7:6] == $past(link.wdat[7:6], 2)) && (CTRL.mode == core.mode);
	endproperty
	a_mode_mirror: assert property (p_mode_mirror) else $error("mode not mirrored");

	property p_timer_reset;
		@(posedge CLK) disable iff (RST)
		$fell(RST) |-> ({core.dct, core.flash_safety_limit} == `TIMER_RST);
	endproperty
	a_timer_reset: assert property (p_timer_reset) else $error("timer reset value");

	property p_flash_safety_limit_once;
		@(posedge CLK) disable iff (RST)
		core.flash_safety_limit_locked |=> $stable(core.flash_safety_limit);
	endproperty
	a_flash_safety_limit_once: assert property (p_flash_safety_limit_once) else $error("safety timer rewritten");

	property p_hi_current;
		@(posedge CLK) disable iff (RST)
		(CTRL.torch >= `TORCH_HI_MIN)
		|-> !$past(core.r1_low[`UNLOCK_BIT]) && $past(core.txm_m[1]) && $past(core.gpio_m[1]);
	endproperty
	a_hi_current: assert property (p_hi_current) else $error("high current unlocked");

	property p_meas;
		@(posedge CLK) disable iff (RST)
		CTRL.meas_start |-> $past(wr_evt) && ($past(core.reg_sel) == `REG_MEAS) &&
			(($past(core.mode) == `MODE_TORCH) || ($past(core.mode) == `MODE_FLASH));
	endproperty
	a_meas: assert property (p_meas) else $error("bad measure start");

	property p_unmapped;
		@(posedge CLK) disable iff (RST)
		(core.reg_sel > `REG_TIMER) ##1 (core.reg_sel > `REG_TIMER) |-> (core.rd_byte == '0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_thermal;
		@(posedge CLK) disable iff (RST)
		(core.reg_sel == `REG_MEAS) |=> (core.rd_byte[7] == $past(core.sense.thermal));
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal bit wrong");

	property p_flash_win;
		@(posedge CLK) disable iff (RST)
		CTRL.flash_en |-> ($past(core.mode) == `MODE_FLASH) && !$past(core.fl_expired);
	endproperty
	a_flash_win: assert property (p_flash_win) else $error("flash out of window");

	c_write: cover property (@(posedge CLK) disable iff (RST) wr_evt);
	c_read: cover property (@(posedge LINK_SCL) disable iff (core.link_reset)
		link.phase == PH_RDATA);
	c_timeout: cover property (@(posedge CLK) disable iff (RST) $rose(CTRL.flash_timeout));
	c_measure: cover property (@(posedge CLK) disable iff (RST) CTRL.meas_start);
	c_gp_timer: cover property (@(posedge CLK) disable iff (RST) $rose(CTRL.timer_expired));

endmodule // led_flash_ctrl_regs
`default_nettype wire

/* dv/i2c_host_model.sv */
// Serial bus master model that drives frames into the register bank
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model
(
	// Bus pins, data is open drain with a pull-up
	output var logic SCL,
	output var logic SDA_LOW,
	input  wire logic SDA
);
	// Idle bus: clock parked high, data released
	initial
	begin
		SCL     = 1'b1;
		SDA_LOW = 1'b0;
	end

	// ----------------------------------------
	// Bus phases, 80 ns clock only inside frames
	// ----------------------------------------
	// Start or repeated start; long hold outlasts the link reset window
	task automatic start_cond();
		SDA_LOW = 1'b0;
		#20 SCL = 1'b1;
		#40 SDA_LOW = 1'b1;
		#240 SCL = 1'b0;
		#20;
	endtask

	// One bit: data set while clock low, sampled mid high phase
	task automatic put_bit(input logic b, output logic seen);
		SDA_LOW = !b;
		#20 SCL = 1'b1;
		#20 seen = SDA;
		#20 SCL = 1'b0;
		#20;
	endtask

	// Byte out MSB first, ninth bit released to take the answer
	task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--)
			put_bit(tx[i], rx[i]);
		put_bit(1'b1, seen);
		ack = !seen;
	endtask

	// Stop returns the slave to waiting for a start
	task automatic stop_cond();
		SDA_LOW = 1'b1;
		#20 SCL = 1'b1;
		#40 SDA_LOW = 1'b0;
		#40;
	endtask

	// ----------------------------------------
	// Whole frames
	// ----------------------------------------
	// Address, select, data, then stop
	task automatic write_frame(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d,
		output logic [2:0] acks);
		logic [7:0] rx;
		#7 start_cond();
		xfer_byte(a, rx, acks[2]);
		xfer_byte(s, rx, acks[1]);
		xfer_byte(d, rx, acks[0]);
		stop_cond();
	endtask

	// Select write, restart, one byte read and refused
	task automatic read_frame(input logic [7:0] s, output logic [7:0] d, output logic [2:0] acks);
		logic ign;
		#7 start_cond();
		xfer_byte(8'h66, d, acks[2]);
		xfer_byte(s, d, acks[1]);
		start_cond();
		xfer_byte(8'h67, d, acks[0]);
		xfer_byte(8'hFF, d, ign);
		stop_cond();
	endtask
endmodule // i2c_host_model

`default_nettype wire

/* dv/led_flash_ctrl_regs_bench.sv */
// Self-checking bench for the LED flash control register bank
`timescale 1ns/1ps
`default_nettype none

module led_flash_ctrl_regs_bench;
	import flash_ctrl_pkg::*;

	// ----------------------------------------
	// Signals and reference state
	// ----------------------------------------
	// Short timer steps keep the run brief
	localparam int unsigned SAFE_CYC = 20;
	localparam int unsigned GP_CYC   = 30;
	localparam int unsigned PWM_CYC  = 1000;

	logic       clk        = 1'b0;
	logic       rst        = 1'b1;
	logic       tx_mask_en = 1'b1;
	logic       gpio_in    = 1'b1;
	sense_s     sense      = '0;
	logic       sda_oe;
	logic       sda_out;
	logic       scl;
	logic       host_low;
	ctrl_out_s  ctrl;
	// Open drain: only a driven low pulls the line, pull-up otherwise
	wire logic  sda_wire   = !((sda_oe && !sda_out) || host_low);
	int         bad_count       = 0;
	int         samples_checked = 0;
	int         meas_cnt        = 0;
	logic [1:0] mode_e = 2'h0;
	logic [1:0] switch_current_limit_select_e = 2'h0;
	logic [5:0] r0_e   = 6'h00;
	logic [4:0] r1_e   = 5'h00;
	logic [2:0] st2_e  = 3'h0;
	logic [2:0] dct_e  = 3'h6;
	logic [4:0] flash_safety_limit_e = 5'h11;
	logic       lock_e = 1'b0;
	logic       to_e   = 1'b0;
	logic [7:0] meas_e = 8'h00;

	led_flash_ctrl_regs
	#(
		.SAFETY_STEP_CYC (SAFE_CYC),
		.GP_STEP_CYC     (GP_CYC),
		.PWM_PERIOD_CYC  (PWM_CYC)
	)
	u_dut
	(
		.CLK        (clk),
		.RST        (rst),
		.LINK_SCL   (scl),
		.SDA_IN     (sda_wire),
		.SDA_OUT    (sda_out),
		.SDA_OE     (sda_oe),
		.TX_MASK_EN (tx_mask_en),
		.GPIO_IN    (gpio_in),
		.SENSE      (sense),
		.CTRL       (ctrl)
	);

	i2c_host_model u_host
	(
		.SCL     (scl),
		.SDA_LOW (host_low),
		.SDA     (sda_wire)
	);

	// Clock and measurement pulse counter
	always #5 clk = !clk;
	always @(posedge clk)
		if (ctrl.meas_start === 1'b1)
			meas_cnt <= meas_cnt + 1;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Reference read value; mode field is shared by two registers
	function automatic logic [7:0] exp_rd(input logic [7:0] s);
		case (s)
			8'h00:   return {mode_e, r0_e};
			8'h01:   return {mode_e, r1_e, to_e};
			8'h02:   return {sense, st2_e};
			8'h03:   return {dct_e, flash_safety_limit_e};
			default: return 8'h00;
		endcase
	endfunction

	// Write, update the reference, then compare the power stage controls
	task automatic wr(input logic [7:0] s, input logic [7:0] d);
		logic [2:0] acks;
		u_host.write_frame(8'h66, s, d, acks);
		check({5'h00, acks}, 8'h07);
		if (s < 8'h02)
			mode_e = d[7:6];
		if (s == 8'h00)
			r0_e = d[5:0];
		if (s == 8'h01)
			r1_e = d[5:1];
		if (s == 8'h02)
		begin
			st2_e  = d[2:0];
			switch_current_limit_select_e = (d[6:5] == 2'h3) ? 2'h2 : d[6:5];
			if (d[5:3] == 3'h7 && (mode_e == 2'h1 || mode_e == 2'h2))
				meas_e++;
		end
		if (s == 8'h03)
		begin
			dct_e = d[7:5];
			if (!lock_e)
				flash_safety_limit_e = d[4:0];
			lock_e = 1'b1;
		end
		if (mode_e == 2'h2)
			lock_e = 1'b1;
		repeat (20) @(negedge clk);
		check({6'h00, ctrl.mode}, {6'h00, mode_e});
		check({6'h00, ctrl.switch_current_limit_select}, {6'h00, switch_current_limit_select_e});
		check(meas_cnt[7:0], meas_e);
	endtask

	task automatic rd(input logic [7:0] s);
		logic [7:0] d;
		logic [2:0] acks;
		u_host.read_frame(s, d, acks);
		check({5'h00, acks}, 8'h07);
		check(d, exp_rd(s));
		@(negedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		logic [7:0] a;
		logic [7:0] s;
		logic [2:0] acks;
		int         pwm_high;
		void'($urandom(91252));
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		rd(8'h03);
		// Foreign, general-call and 10-bit headers must stay unanswered
		for (int i = 0; i < 3; i++)
		begin
			a = (i == 0) ? (8'($urandom_range(8'h68, 8'hFE)) & 8'hFE) : ((i == 1) ? 8'h00 : 8'hF0);
			u_host.write_frame(a, 8'h03, 8'h00, acks);
			check({5'h00, acks}, 8'h00);
		end
		rd(8'h03);
		// Safety field takes its first write only
		wr(8'h02, 8'h00);
		wr(8'h03, 8'hC3);
		wr(8'h03, 8'hDF);
		rd(8'h03);
		// Random traffic over mapped and unmapped selects, mode kept off
		repeat (10)
		begin
			sense = 5'($urandom);
			s = 8'($urandom_range(0, 7));
			wr(s, 8'($urandom) & 8'h3F);
			rd(s);
		end
		// Tripped thermal sensor shows in the top bit of register two
		sense = 5'h12;
		rd(8'h02);
		rd(8'hFF);
		// Torch mode through register one, mirrored in register zero
		wr(8'h01, 8'h40);
		check({7'h00, ctrl.torch_pwm}, 8'h01);
		rd(8'h00);
		wr(8'h00, 8'h7D);
		check({5'h00, ctrl.torch}, 8'h07);
		check({5'h00, ctrl.flash}, {5'h00, r0_e[2:0]});
		gpio_in = 1'b0;
		repeat (10) @(negedge clk);
		check({5'h00, ctrl.torch}, 8'h05);
		gpio_in = 1'b1;
		repeat (10) @(negedge clk);
		check({5'h00, ctrl.torch}, 8'h07);
		tx_mask_en = 1'b0;
		repeat (10) @(negedge clk);
		check({5'h00, ctrl.torch}, 8'h05);
		tx_mask_en = 1'b1;
		wr(8'h01, 8'h60);
		check({5'h00, ctrl.torch}, 8'h05);
		// Top duty code, 8.6 percent, counted over one whole PWM period
		wr(8'h03, 8'hE0);
		wr(8'h01, 8'h50);
		pwm_high = 0;
		repeat (PWM_CYC)
		begin
			@(negedge clk);
			if (ctrl.torch_pwm === 1'b1)
				pwm_high++;
		end
		check(8'(pwm_high), 8'h56);
		// Trigger bits and limit field share bit 5
		for (int i = 0; i < 4; i++)
			wr(8'h02, {1'b0, 2'(i), 5'h18});
		// Flash mode, safety limit of 3 steps
		wr(8'h01, 8'h80);
		check({7'h00, ctrl.flash_en}, 8'h01);
		check({7'h00, ctrl.flash_timeout}, 8'h00);
		repeat (45) @(negedge clk);
		check({7'h00, ctrl.flash_timeout}, 8'h01);
		// Voltage mode, general timer of 6 steps
		wr(8'h03, 8'hC0);
		wr(8'h01, 8'hC0);
		repeat (130) @(negedge clk);
		check({7'h00, ctrl.timer_expired}, 8'h00);
		repeat (50) @(negedge clk);
		check({7'h00, ctrl.timer_expired}, 8'h01);
		to_e = 1'b1;
		rd(8'h01);
		tally_and_finish();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#800us;
		bad_count++;
		tally_and_finish();
	end
endmodule // led_flash_ctrl_regs_bench

`default_nettype wire
